/* File: logic/etp_pkg.sv */
/*
  Package for the eight-bit timer with shared prescaler.
  Holds register offsets, field positions, reset values and timing counts.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package etp_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_TICK_COUNTER_VALUE = 8'h01;
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] ADDR_OPTION_CONFIGURATION = 8'h81;

  // Option register fields
  localparam int OPT_COUNT_SOURCE_SELECT = 5;
  localparam int OPT_COUNT_EDGE_SELECT = 4;
  localparam int OPT_PRESCALER_ASSIGN = 3;
  localparam int OPT_RATE_MSB = 2;
  localparam int OPT_RATE_LSB = 0;
  localparam logic [7:0] OPTION_RESET = 8'hFF;

  // Interrupt control fields
  localparam int ICTL_OVERFLOW_IRQ_ENABLE = 5;
  localparam int ICTL_OVERFLOW_FLAG = 2;
  localparam logic [7:0] ICTL_RESET = 8'h00;

  // Counter reset value
  localparam logic [7:0] TICK_RESET = 8'h00;

  // Instruction cycle is four core clocks (four phases)
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // Phases on which the pin is sampled (second and fourth)
  localparam logic [1:0] PHASE_SAMPLE_A = 2'h1;
  localparam logic [1:0] PHASE_SAMPLE_B = 2'h3;
  // Instruction cycles of counting inhibit after a counter write
  localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;

  // Prescaler width
  localparam int PRESCALE_WIDTH = 8;

  // Sampled pin pair carried together
  typedef struct packed {
    logic now;
    logic prev;
  } etp_pin_t;

endpackage

/* File: logic/etp_timer.sv */
/*
  Eight-bit timer/counter with one prescaler shared with the watchdog.
  Assumes the core supplies one instruction cycle as four i_clk periods,
  a sleep level, a watchdog-clear pulse, and a plain register port.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RL1) Source bit picks instruction cycle or pin
// (RL2) Counter write holds counting two cycles
// (RL3) Edge bit: 0 rising, 1 falling
// (RL4) Wrap FFh to 00h sets overflow flag
// (RL5) Interrupt raised only while enable set
// (RL6) Software clears flag before re-enabling interrupt
// (RL7) Counter stops while asleep
// (RL8) Pin sampled on second and fourth phase
// (RL9) Pin high and low two oscillator periods
// (RL10) One prescaler, timer or watchdog only
// (RL11) Assign bit set: watchdog, clear: timer
// (RL12) Timer rate divides by two to code+1
// (RL13) Watchdog rate divides by two to code
// (RL14) Prescaler count hidden from software
// (RL15) Counter write clears prescaler when assigned to timer, keeps assignment
// (RL16) Watchdog clear resets watchdog, and prescaler when assigned to watchdog
// (RL17) Software sequence when moving prescaler to watchdog
// (RL18) Flag set regardless of enable bit
module etp_timer
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Core status
  input wire logic i_sleep,
  input wire logic i_watchdog_clear_instruction,
  input wire logic i_watchdog_tick,
  // External count pin
  input wire logic i_external_count_pin,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  // Outputs
  output logic o_irq,
  output logic o_watchdog_tick,
  output logic o_watchdog_clear
);

  // Registers
  logic [7:0] tick_counter_value;
  logic [7:0] option_configuration;
  logic overflow_irq_enable;
  logic overflow_flag;
  // Instruction phase counter
  logic [1:0] phase;
  // Pin synchroniser stages
  logic pin_meta;
  logic pin_sync;
  // Phase-sampled pin, current and previous
  etp_pkg::etp_pin_t pin_smp;
  // Inhibit countdown in instruction cycles
  logic [1:0] inhibit;
  // Hidden prescaler count
  logic [etp_pkg::PRESCALE_WIDTH-1:0] prescale_count;
  // Per-bit select for prescaler taps
  logic [7:0] tap_mask;

  // Decoded fields
  logic count_source_select;
  logic count_edge_select;
  logic prescaler_assign;
  logic [2:0] prescale_rate;
  logic cycle_end;
  logic pin_edge;
  logic source_tick;
  logic wd_source_tick;
  logic pre_in;
  logic pre_out;
  logic timer_tick;
  logic tick_write;
  logic ictl_write;
  logic opt_write;
  logic [etp_pkg::PRESCALE_WIDTH-1:0] next_prescale_count;

  assign count_source_select = option_configuration[etp_pkg::OPT_COUNT_SOURCE_SELECT];
  assign count_edge_select = option_configuration[etp_pkg::OPT_COUNT_EDGE_SELECT];
  assign prescaler_assign = option_configuration[etp_pkg::OPT_PRESCALER_ASSIGN];
  assign prescale_rate = option_configuration[etp_pkg::OPT_RATE_MSB:etp_pkg::OPT_RATE_LSB];
  assign cycle_end = (phase == etp_pkg::PHASE_LAST);

  // Address decode for writes
  always_comb
  begin
    tick_write = 1'b0;
    ictl_write = 1'b0;
    opt_write = 1'b0;
    if (i_write && i_addr == etp_pkg::ADDR_TICK_COUNTER_VALUE)
    begin
      tick_write = 1'b1;
    end
    else if (i_write && i_addr == etp_pkg::ADDR_INTERRUPT_CONTROL)
    begin
      ictl_write = 1'b1;
    end
    else if (i_write && i_addr == etp_pkg::ADDR_OPTION_CONFIGURATION)
    begin
      opt_write = 1'b1;
    end
  end

  // Four-phase instruction cycle; frozen in sleep, while the synchroniser and the watchdog-side prescaler keep running
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      phase <= 2'h0;
    end
    else if (i_ce && !i_sleep)
    begin
      phase <= phase + 2'h1;
    end
  end

  // Two-flop synchroniser; first stage read only by second
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else if (i_ce)
    begin
      pin_meta <= i_external_count_pin;
      pin_sync <= pin_meta;
    end
  end

  // (RL8) Phase two/four sampling
  // Pulses shorter than two phases can be missed by design.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pin_smp <= '0;
    end
    else if (i_ce && !i_sleep && (phase == etp_pkg::PHASE_SAMPLE_A || phase == etp_pkg::PHASE_SAMPLE_B))
    begin
      pin_smp.prev <= pin_smp.now;
      pin_smp.now <= pin_sync;
    end
  end

  // (RL3) Edge polarity select
  // At phase four the pair holds last cycle's fourth and this cycle's second sample;
  // the live fourth sample closes the window, so an edge in either half counts once.
  assign pin_edge = count_edge_select ?
    ((pin_smp.prev && !pin_smp.now) || (pin_smp.now && !pin_sync)) :
    ((!pin_smp.prev && pin_smp.now) || (!pin_smp.now && pin_sync));

  // (RL1) Source select
  // Pin edge is acted on once per instruction cycle at its end
  assign source_tick = cycle_end && (count_source_select ? pin_edge : 1'b1);

  // (RL10) One prescaler input, by assignment
  assign wd_source_tick = i_watchdog_tick;
  // (RL11) Route by assign bit
  assign pre_in = prescaler_assign ? wd_source_tick : source_tick;

  // Tap select: bit k set means count bits 0..k all ones
  generate
    for (genvar k = 0; k < 8; k++)
    begin : g_tap
      assign tap_mask[k] = &prescale_count[k:0];
    end
  endgenerate

  // (RL12) (RL13) Tap by rate: timer 2^(code+1), watchdog 2^code
  always_comb
  begin
    pre_out = 1'b0;
    if (prescaler_assign)
    begin
      if (prescale_rate == 3'h0)
      begin
        pre_out = pre_in;
      end
      else
      begin
        pre_out = pre_in && tap_mask[3'(prescale_rate - 3'h1)];
      end
    end
    else
    begin
      pre_out = pre_in && tap_mask[prescale_rate];
    end
  end

  // (RL10) Side without the prescaler runs undivided
  assign timer_tick = prescaler_assign ? source_tick : pre_out;

  // Prescaler next value
  always_comb
  begin
    next_prescale_count = prescale_count;
    if (pre_in && !pre_out)
    begin
      next_prescale_count = prescale_count + 8'h01;
    end
    else if (pre_out)
    begin
      next_prescale_count = 8'h00;
    end
  end

  // (RL14) Prescaler count has no register address
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      prescale_count <= 8'h00;
    end
    else if (i_ce)
    begin
      // (RL15) Counter write clears prescaler
      if (tick_write && !prescaler_assign)
      begin
        prescale_count <= 8'h00;
      end
      // (RL16) Watchdog clear clears prescaler
      else if (i_watchdog_clear_instruction && prescaler_assign)
      begin
        prescale_count <= 8'h00;
      end
      // (RL7) Timer side frozen in sleep
      else if (!i_sleep || prescaler_assign)
      begin
        prescale_count <= next_prescale_count;
      end
    end
  end

  // (RL16) Watchdog clear and tick handed to the watchdog unit
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_watchdog_clear <= 1'b0;
      o_watchdog_tick <= 1'b0;
    end
    else if (i_ce)
    begin
      o_watchdog_clear <= i_watchdog_clear_instruction;
      o_watchdog_tick <= prescaler_assign ? pre_out : wd_source_tick;
    end
  end

  // (RL2) Two-cycle inhibit after counter write
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      inhibit <= 2'h0;
    end
    else if (i_ce)
    begin
      if (tick_write)
      begin
        inhibit <= etp_pkg::WRITE_INHIBIT_CYCLES;
      end
      else if (cycle_end && !i_sleep && inhibit != 2'h0)
      begin
        inhibit <= inhibit - 2'h1;
      end
    end
  end

  // Counter; write wins over increment
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tick_counter_value <= etp_pkg::TICK_RESET;
    end
    else if (i_ce)
    begin
      if (tick_write)
      begin
        tick_counter_value <= i_wdata;
      end
      // (RL7) No counting asleep
      else if (timer_tick && !i_sleep && inhibit == 2'h0)
      begin
        tick_counter_value <= tick_counter_value + 8'h01;
      end
    end
  end

  // Option register, reset to all ones
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      option_configuration <= etp_pkg::OPTION_RESET;
    end
    else if (i_ce && opt_write)
    begin
      // (RL17) Reassignment safety left to software
      option_configuration <= i_wdata;
    end
  end

  // Interrupt control: enable bit and sticky flag
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      overflow_irq_enable <= 1'b0;
      overflow_flag <= 1'b0;
    end
    else if (i_ce)
    begin
      if (ictl_write)
      begin
        overflow_irq_enable <= i_wdata[etp_pkg::ICTL_OVERFLOW_IRQ_ENABLE];
      end
      // (RL4) (RL18) Wrap sets flag, set beats clear
      if (!tick_write && timer_tick && !i_sleep && inhibit == 2'h0 && tick_counter_value == 8'hFF)
      begin
        overflow_flag <= 1'b1;
      end
      // (RL6) Write one clears flag
      else if (ictl_write && i_wdata[etp_pkg::ICTL_OVERFLOW_FLAG])
      begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // (RL5) Masked level interrupt
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_irq <= 1'b0;
    end
    else if (i_ce)
    begin
      o_irq <= overflow_flag && overflow_irq_enable;
    end
  end

  // Read data one cycle after strobe; unmapped reads zero
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_ce)
    begin
      if (!i_read)
      begin
        o_rdata <= 8'h00;
      end
      else if (i_addr == etp_pkg::ADDR_TICK_COUNTER_VALUE)
      begin
        o_rdata <= tick_counter_value;
      end
      else if (i_addr == etp_pkg::ADDR_INTERRUPT_CONTROL)
      begin
        o_rdata <= {2'h0, overflow_irq_enable, 2'h0, overflow_flag, 2'h0};
      end
      else if (i_addr == etp_pkg::ADDR_OPTION_CONFIGURATION)
      begin
        o_rdata <= option_configuration;
      end
      else
      begin
        o_rdata <= 8'h00;
      end
    end
  end

endmodule
`default_nettype wire

/* File: dv/etp_timer_props.sv */
/* Port checker for the timer block.
   Assumes one clock, bound from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module etp_timer_props
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Inputs
  input wire logic i_watchdog_clear_instruction,
  input wire logic i_watchdog_tick,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  // Outputs
  input wire logic [7:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_watchdog_tick,
  input wire logic o_watchdog_clear
);
  // Shadows of option and enable
  logic [7:0] opt;
  logic en;
  logic wr_ic;
  assign wr_ic = i_write && i_addr == etp_pkg::ADDR_INTERRUPT_CONTROL;
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      opt <= etp_pkg::OPTION_RESET;
      en <= 1'b0;
    end
    else
    begin
      if (i_write && i_addr == etp_pkg::ADDR_OPTION_CONFIGURATION)
        opt <= i_wdata;
      if (wr_ic)
        en <= i_wdata[etp_pkg::ICTL_OVERFLOW_IRQ_ENABLE];
    end
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_rd_opt;
    i_read && i_addr == etp_pkg::ADDR_OPTION_CONFIGURATION;
  endsequence
  sequence s_wd_direct;
    !opt[etp_pkg::OPT_PRESCALER_ASSIGN] && i_watchdog_tick;
  endsequence
  a_opt_readback: assert property (s_rd_opt |=> o_rdata == opt)
    else $error("option readback wrong");
  a_rdata_idle: assert property (!i_read |=> o_rdata == 8'h00)
    else $error("read data not idle");
  a_clear_echo: assert property (i_watchdog_clear_instruction |=> o_watchdog_clear)
    else $error("watchdog clear lost");
  a_clear_cause: assert property (o_watchdog_clear |-> $past(i_watchdog_clear_instruction))
    else $error("spurious watchdog clear");
  a_wd_direct: assert property (s_wd_direct |=> o_watchdog_tick)
    else $error("watchdog tick not direct");
  a_wd_cause: assert property (o_watchdog_tick |-> $past(i_watchdog_tick))
    else $error("spurious watchdog tick");
  a_irq_masked: assert property (o_irq |-> en || $past(en))
    else $error("masked interrupt raised");
  a_irq_sticky: assert property (o_irq && !wr_ic && !$past(wr_ic) |=> o_irq)
    else $error("interrupt dropped alone");
endmodule
`default_nettype wire

/* File: dv/etp_pin_source.sv */
/* External source for the count pin.
   Assumes toggle is called right after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module etp_pin_source
(
  // Clock
  input wire logic i_clk,
  // Pin level, idle between bursts
  output logic o_pin
);
  initial o_pin = 1'b0;
  // Flip the pin n times
  task automatic toggle(input int n);
    repeat (n)
    begin
      o_pin <= ~o_pin;
      repeat (4) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/tb_eight_bit_timer_shared_prescaler.sv */
/* Bench for the timer block.
   Assumes the package, checker and pin source are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_eight_bit_timer_shared_prescaler;
  localparam logic [7:0] A_T = etp_pkg::ADDR_TICK_COUNTER_VALUE;
  localparam logic [7:0] A_I = etp_pkg::ADDR_INTERRUPT_CONTROL;
  localparam logic [7:0] A_O = etp_pkg::ADDR_OPTION_CONFIGURATION;
  // Stimulus, response, counters
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sleep = 1'b0;
  logic wclr = 1'b0;
  logic wtick = 1'b0;
  logic write = 1'b0;
  logic read = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, v;
  logic pin, irq, wd_tick;
  int n_fail = 0;
  int checks = 0;
  int wd_n = 0;
  int cyc = 0;
  etp_timer i_dut (.i_clk(clk), .i_reset(reset), .i_ce(1'b1), .i_sleep(sleep),
    .i_watchdog_clear_instruction(wclr), .i_watchdog_tick(wtick), .i_external_count_pin(pin),
    .i_addr(addr), .i_wdata(wdata), .i_write(write), .i_read(read), .o_rdata(rdata),
    .o_irq(irq), .o_watchdog_tick(wd_tick), .o_watchdog_clear());
  etp_pin_source i_src (.i_clk(clk), .o_pin(pin));
  initial
  begin
    forever #20 clk = ~clk;
  end
  // Count watchdog pulses; ceiling cuts a hang
  always @(posedge clk)
  begin
    cyc++;
    if (wd_tick === 1'b1)
      wd_n++;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clk);
    write <= 1'b0;
  endtask
  // Read lands one clock after the strobe edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    read <= 1'b1;
    @(posedge clk);
    read <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      wtick <= 1'b1;
      @(posedge clk);
      wtick <= 1'b0;
    end
  endtask
  // Wait k instruction cycles after a write, then read counter
  task automatic cnt_after(input int k);
    repeat (4 * k - 1) @(posedge clk);
    rd(A_T);
  endtask
  task automatic t_reset();
    rd(A_O);
    chk(v, 8'hFF);
    rd(8'h55);
    chk(v, 8'h00);
  endtask
  task automatic t_timer();
    wr(A_O, 8'h08);
    wr(A_T, 8'h10);
    cnt_after(5);
    chk(v, 8'h13);
  endtask
  task automatic t_ovf();
    wr(A_I, 8'h20);
    wr(A_T, 8'hFE);
    cnt_after(6);
    chk(v, 8'h02);
    chk({7'h00, irq}, 8'h01);
    wr(A_I, 8'h00);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rd(A_I);
    chk(v, 8'h04);
    wr(A_I, 8'h04);
    rd(A_I);
    chk(v, 8'h00);
  endtask
  task automatic t_sleep();
    @(posedge clk);
    sleep <= 1'b1;
    wr(A_T, 8'h40);
    cnt_after(10);
    chk(v, 8'h40);
    @(posedge clk);
    sleep <= 1'b0;
  endtask
  task automatic t_tmr_rate();
    for (int c = 0; c < 8; c++)
    begin
      wr(A_O, c[7:0]);
      wr(A_T, 8'h00);
      cnt_after(2 * (2 << c) + 2);
      chk(v, 8'h02);
      rd(A_O);
      chk(v, c[7:0]);
    end
    wd_n = 0;
    tick(3);
    repeat (2) @(posedge clk);
    chk(wd_n[7:0], 8'h03);
  endtask
  task automatic t_wd_rate();
    // Clear prescaler before handing it over
    wr(A_T, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wr(A_O, 8'h08 | c[7:0]);
      tick((1 << c) >> 1);
      @(posedge clk);
      wclr <= 1'b1;
      @(posedge clk);
      wclr <= 1'b0;
      wd_n = 0;
      tick((2 << c) - 1);
      repeat (2) @(posedge clk);
      chk(wd_n[7:0], 8'h01);
    end
  endtask
  task automatic t_pin();
    for (int e = 0; e < 2; e++)
    begin
      wr(A_O, 8'h28 | (e[7:0] << 4));
      wr(A_T, 8'h00);
      repeat (12) @(posedge clk);
      i_src.toggle(5);
      repeat (16) @(posedge clk);
      rd(A_T);
      chk(v, 8'h03);
    end
  endtask
  task automatic stop_test();
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_timer();
    t_ovf();
    t_sleep();
    t_tmr_rate();
    t_wd_rate();
    t_pin();
    stop_test();
  end
endmodule
bind etp_timer etp_timer_props i_props (.i_clk(i_clk), .i_reset(i_reset),
  .i_watchdog_clear_instruction(i_watchdog_clear_instruction), .i_watchdog_tick(i_watchdog_tick),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
  .o_irq(o_irq), .o_watchdog_tick(o_watchdog_tick), .o_watchdog_clear(o_watchdog_clear));
`default_nettype wire
